// ### pkg/ceflg_defines.svh
`ifndef CEFLG_DEFINES_SVH
`define CEFLG_DEFINES_SVH

// Register byte offsets on the APB slave.
`define CEFLG_OFS_IN_PATH 12'h000
`define CEFLG_OFS_OUTA_PATH 12'h004
`define CEFLG_OFS_OUTB_PATH 12'h008
`define CEFLG_OFS_ASRC_PATH 12'h00C
`define CEFLG_OFS_FX_PATH 12'h010
`define CEFLG_OFS_MIX_PATH 12'h014
`define CEFLG_OFS_PIN_FN 12'h018
`define CEFLG_OFS_BUDGET 12'h01C
`define CEFLG_OFS_RAW 12'h020
`define CEFLG_OFS_INT_STS 12'h024
`define CEFLG_OFS_INT_CLR 12'h028
`define CEFLG_OFS_INT_EN 12'h02C
`define CEFLG_OFS_SUB_STS 12'h030

// Pin function codes.
`define CEFLG_FN_SYS_UNDER 8'h0A
`define CEFLG_FN_ASYNC_UNDER 8'h0B
`define CEFLG_FN_ADC_OVF 8'h17
`define CEFLG_FN_ADC_CIC 8'h18
`define CEFLG_FN_ADC_FIFO 8'h19
`define CEFLG_FN_MIX_DROP 8'h27
`define CEFLG_FN_UNDER 8'h2D
`define CEFLG_FN_OVER 8'h2E

// Bit positions of the flag vector and of the interrupt registers.
`define CEFLG_BIT_SYS_UNDER 0
`define CEFLG_BIT_ASYNC_UNDER 1
`define CEFLG_BIT_ADC_OVF 2
`define CEFLG_BIT_ADC_CIC 3
`define CEFLG_BIT_ADC_FIFO 4
`define CEFLG_BIT_MIX_DROP 5
`define CEFLG_BIT_UNDER 6
`define CEFLG_BIT_OVER 7

// Reset values.
`define CEFLG_RST_BUDGET 32'h0040_0040
`define CEFLG_RST_PIN_FN 16'h0000
`define CEFLG_RST_INT_EN 8'h00

// Processing cycles that one active path costs, and the device ceiling.
`define CEFLG_SYS_COST 16'h0004
`define CEFLG_ASYNC_COST 16'h0008
`define CEFLG_DEV_MAX 16'h0080

`endif

// ### pkg/ceflg_pkg.sv
package ceflg_pkg;

    typedef logic [7:0] ceflg_fn_t;
    typedef logic [7:0] ceflg_flags_t;
    typedef logic [35:0] ceflg_sys_vec_t;
    typedef logic [3:0] ceflg_async_vec_t;

endpackage

// ### rtl/ceflg_top.sv
// How it works
// - Code 0Bh drives the secondary-clock underclock flag.
// - Code 17h drives the ADC overflow flag.
// - Code 18h drives the decimation filter error flag.
// - Code 19h drives the input FIFO error flag.
// - Code 27h drives the mixer dropped-sample flag.
// - Code 2Dh drives the aggregate underclocked flag.
// - Input path active flags are readable.
// - Output path active flags span two registers.
// - Rate converter path active flags are readable.
// - Effects path active field is readable.
// - Mixer path active fields feed the aggregate.
// - Sync converters and serial ports also feed it.
// - Code 2Eh drives the overclocked flag.
// - Code 0Ah drives the core-clock underclock flag.
// - Both edges of each flag latch interrupts.
// - Refuse enables lacking cycles; keep running paths.
`timescale 1ns/1ps
`default_nettype none
`include "ceflg_defines.svh"

module ceflg_top
    import ceflg_pkg::*;
#(
    parameter int NPINS = 2
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic adc_overflow,
    input wire logic adc_cic_error,
    input wire logic adc_fifo_error,
    input wire logic mixer_drop,
    input wire logic sync_rate_converter_underclock,
    input wire logic serial_audio_port_underclock,
    output logic [NPINS-1:0] pin_out,
    output logic irq
);

    // The pin selection register holds two 8-bit codes, so at most two pins.
    if (NPINS < 1 || NPINS > 2)
    begin : g_bad_npins
        $error("ceflg_top: NPINS must lie between 1 and 2");
    end

    // Number of set bits in a path vector.
    function automatic logic [5:0] ceflg_count(input ceflg_sys_vec_t v);
        logic [5:0] n;
        n = 6'h00;
        for (int i = 0; i < 36; i++)
        begin
            n = n + {5'h00, v[i]};
        end
        return n;
    endfunction

    // Lowest set bit of a path vector, as a one-hot value.
    function automatic ceflg_sys_vec_t ceflg_lowest(input ceflg_sys_vec_t v);
        return v & (~v + 36'h0_0000_0001);
    endfunction

    // Cycles needed by n paths of a given cost.
    function automatic logic [21:0] ceflg_load(input logic [5:0] n, input logic [15:0] cost);
        return 22'(n * cost);
    endfunction

    // Pin function multiplexer; an unknown code leaves the pin low.
    function automatic logic ceflg_pick(input ceflg_fn_t code, input ceflg_flags_t f);
        logic r;
        r = 1'b0;
        case (code)
            `CEFLG_FN_SYS_UNDER: r = f[`CEFLG_BIT_SYS_UNDER];
            `CEFLG_FN_ASYNC_UNDER: r = f[`CEFLG_BIT_ASYNC_UNDER];
            `CEFLG_FN_ADC_OVF: r = f[`CEFLG_BIT_ADC_OVF];
            `CEFLG_FN_ADC_CIC: r = f[`CEFLG_BIT_ADC_CIC];
            `CEFLG_FN_ADC_FIFO: r = f[`CEFLG_BIT_ADC_FIFO];
            `CEFLG_FN_MIX_DROP: r = f[`CEFLG_BIT_MIX_DROP];
            `CEFLG_FN_UNDER: r = f[`CEFLG_BIT_UNDER];
            `CEFLG_FN_OVER: r = f[`CEFLG_BIT_OVER];
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    // Software requested enables and the paths actually running.
    // Core-clock vector: in[7:0], outa[15:8], outb[23:16], fx[27:24], mix[35:28].
    ceflg_sys_vec_t sys_req_q;
    ceflg_sys_vec_t sys_act_q;
    ceflg_async_vec_t async_req_q;
    ceflg_async_vec_t async_act_q;
    logic [15:0] sys_budget_q;
    logic [15:0] async_budget_q;
    logic [15:0] pin_fn_q;
    ceflg_flags_t flags_q;
    ceflg_flags_t flags_prev_q;
    ceflg_flags_t int_sts_q;
    ceflg_flags_t int_en_q;
    logic [6:0] sub_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic [NPINS-1:0] pin_q;
    logic irq_q;

    logic access;
    logic wr;
    logic mapped;
    ceflg_sys_vec_t sys_pend;
    ceflg_sys_vec_t sys_pick;
    ceflg_sys_vec_t async_pend;
    ceflg_sys_vec_t async_pick;
    ceflg_sys_vec_t async_act_w;
    ceflg_sys_vec_t async_req_w;
    logic sys_fit;
    logic async_fit;
    logic [6:0] sub_d;
    logic sys_under;
    logic async_under;
    logic over;
    ceflg_flags_t flags_d;
    ceflg_flags_t int_set;
    ceflg_flags_t int_clr;
    logic [31:0] rd_d;

    assign access = psel & penable & ~pready_q;
    assign wr = psel & penable & pready_q & pwrite & mapped;

    always_comb
    begin
        unique case (paddr)
            `CEFLG_OFS_IN_PATH, `CEFLG_OFS_OUTA_PATH, `CEFLG_OFS_OUTB_PATH,
            `CEFLG_OFS_ASRC_PATH, `CEFLG_OFS_FX_PATH, `CEFLG_OFS_MIX_PATH,
            `CEFLG_OFS_PIN_FN, `CEFLG_OFS_BUDGET, `CEFLG_OFS_RAW,
            `CEFLG_OFS_INT_STS, `CEFLG_OFS_INT_CLR, `CEFLG_OFS_INT_EN,
            `CEFLG_OFS_SUB_STS: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // Admission: at most one pending path per domain is started each cycle, and
    // only if the total load with it still fits the clock budget. A refused path
    // stays pending, so it is retried once software raises the budget.
    assign sys_pend = sys_req_q & ~sys_act_q;
    assign sys_pick = ceflg_lowest(sys_pend);
    assign sys_fit = ceflg_load(ceflg_count(sys_act_q) + 6'h01, `CEFLG_SYS_COST)
                     <= {6'h00, sys_budget_q};
    assign async_act_w = {32'h0000_0000, async_act_q};
    assign async_req_w = {32'h0000_0000, async_req_q};
    assign async_pend = async_req_w & ~async_act_w;
    assign async_pick = ceflg_lowest(async_pend);
    assign async_fit = ceflg_load(ceflg_count(async_act_w) + 6'h01, `CEFLG_ASYNC_COST)
                       <= {6'h00, async_budget_q};

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sys_req_q <= '0;
            async_req_q <= '0;
        end
        else if (wr)
        begin
            unique case (paddr)
                `CEFLG_OFS_IN_PATH: sys_req_q[7:0] <= pwdata[7:0];
                `CEFLG_OFS_OUTA_PATH: sys_req_q[15:8] <= pwdata[7:0];
                `CEFLG_OFS_OUTB_PATH: sys_req_q[23:16] <= pwdata[7:0];
                `CEFLG_OFS_FX_PATH: sys_req_q[27:24] <= pwdata[3:0];
                `CEFLG_OFS_MIX_PATH: sys_req_q[35:28] <= pwdata[7:0];
                `CEFLG_OFS_ASRC_PATH: async_req_q <= pwdata[3:0];
                default:
                begin
                end
            endcase
        end
    end

    // Disabling is immediate; an enable never stops a path already running.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sys_act_q <= '0;
            async_act_q <= '0;
        end
        else
        begin
            sys_act_q <= (sys_act_q & sys_req_q) | (sys_fit ? sys_pick : '0);
            async_act_q <= (async_act_q & async_req_q) | (async_fit ? async_pick[3:0] : 4'h0);
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sys_budget_q <= 16'(`CEFLG_RST_BUDGET);
            async_budget_q <= 16'(`CEFLG_RST_BUDGET >> 16);
            pin_fn_q <= `CEFLG_RST_PIN_FN;
            int_en_q <= `CEFLG_RST_INT_EN;
        end
        else if (wr)
        begin
            if (paddr == `CEFLG_OFS_BUDGET)
            begin
                sys_budget_q <= pwdata[15:0];
                async_budget_q <= pwdata[31:16];
            end
            if (paddr == `CEFLG_OFS_PIN_FN)
            begin
                pin_fn_q <= pwdata[15:0];
            end
            if (paddr == `CEFLG_OFS_INT_EN)
            begin
                int_en_q <= pwdata[7:0];
            end
        end
    end

    // Subsystem underclock sources: a selected path left waiting for cycles, or one of the two external underclock inputs.
    always_comb
    begin
        sub_d[0] = |(sys_req_q[7:0] & ~sys_act_q[7:0]);
        sub_d[1] = |(sys_req_q[23:8] & ~sys_act_q[23:8]);
        sub_d[2] = |(async_req_q & ~async_act_q);
        sub_d[3] = |(sys_req_q[27:24] & ~sys_act_q[27:24]);
        sub_d[4] = |(sys_req_q[35:28] & ~sys_act_q[35:28]);
        sub_d[5] = sync_rate_converter_underclock;
        sub_d[6] = serial_audio_port_underclock;
        sys_under = sub_d[0] | sub_d[1] | sub_d[3] | sub_d[4] | sub_d[5] | sub_d[6];
        async_under = sub_d[2];
        // The ceiling applies to what is asked for, not to what was admitted.
        over = (ceflg_load(ceflg_count(sys_req_q), `CEFLG_SYS_COST)
                > {6'h00, `CEFLG_DEV_MAX})
               || (ceflg_load(ceflg_count(async_req_w), `CEFLG_ASYNC_COST)
                > {6'h00, `CEFLG_DEV_MAX});
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sub_q <= '0;
        end
        else
        begin
            sub_q <= sub_d;
        end
    end

    // Flags are registered so that pins and interrupts see the same clean value,
    // two cycles after an ADC or mixer input changes.
    always_comb
    begin
        flags_d = '0;
        flags_d[`CEFLG_BIT_SYS_UNDER] = sub_q[0] | sub_q[1] | sub_q[3] | sub_q[4]
                                        | sub_q[5] | sub_q[6];
        flags_d[`CEFLG_BIT_ASYNC_UNDER] = sub_q[2];
        flags_d[`CEFLG_BIT_ADC_OVF] = adc_overflow;
        flags_d[`CEFLG_BIT_ADC_CIC] = adc_cic_error;
        flags_d[`CEFLG_BIT_ADC_FIFO] = adc_fifo_error;
        flags_d[`CEFLG_BIT_MIX_DROP] = mixer_drop;
        flags_d[`CEFLG_BIT_UNDER] = |sub_q;
        flags_d[`CEFLG_BIT_OVER] = over;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            flags_q <= '0;
            flags_prev_q <= '0;
        end
        else
        begin
            flags_q <= flags_d;
            flags_prev_q <= flags_q;
        end
    end

    // Either edge latches the bit; a new edge wins over a clear in the same cycle.
    assign int_set = flags_q ^ flags_prev_q;
    assign int_clr = (wr && paddr == `CEFLG_OFS_INT_CLR) ? pwdata[7:0] : 8'h00;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            int_sts_q <= '0;
        end
        else
        begin
            int_sts_q <= (int_sts_q & ~int_clr) | int_set;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_q <= 1'b0;
        end
        else
        begin
            irq_q <= |(((int_sts_q & ~int_clr) | int_set) & int_en_q);
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_q <= '0;
        end
        else
        begin
            for (int p = 0; p < NPINS; p++)
            begin
                pin_q[p] <= ceflg_pick(pin_fn_q[p*8 +: 8], flags_q);
            end
        end
    end

    always_comb
    begin
        rd_d = 32'h0000_0000;
        unique case (paddr)
            `CEFLG_OFS_IN_PATH: rd_d[7:0] = sys_act_q[7:0];
            `CEFLG_OFS_OUTA_PATH: rd_d[7:0] = sys_act_q[15:8];
            `CEFLG_OFS_OUTB_PATH: rd_d[7:0] = sys_act_q[23:16];
            `CEFLG_OFS_ASRC_PATH: rd_d[3:0] = async_act_q;
            `CEFLG_OFS_FX_PATH: rd_d[3:0] = sys_act_q[27:24];
            `CEFLG_OFS_MIX_PATH: rd_d[7:0] = sys_act_q[35:28];
            `CEFLG_OFS_PIN_FN: rd_d[15:0] = pin_fn_q;
            `CEFLG_OFS_BUDGET: rd_d = {async_budget_q, sys_budget_q};
            `CEFLG_OFS_RAW: rd_d[7:0] = flags_q;
            `CEFLG_OFS_INT_STS: rd_d[7:0] = int_sts_q;
            `CEFLG_OFS_INT_EN: rd_d[7:0] = int_en_q;
            `CEFLG_OFS_SUB_STS: rd_d[6:0] = sub_q;
            default: rd_d = 32'h0000_0000;
        endcase
    end

    // One wait state keeps pready and prdata straight from flip-flops.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end
        else
        begin
            pready_q <= access;
            pslverr_q <= access & ~mapped;
            prdata_q <= (access && !pwrite) ? rd_d : 32'h0000_0000;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign pin_out = pin_q;
    assign irq = irq_q;

endmodule

`default_nettype wire

// ### verif/ceflg_far_end.sv
`timescale 1ns/1ps
`default_nettype none
module ceflg_far_end #(
    parameter int NPINS = 2
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [NPINS-1:0] pin_out,
    input wire logic irq,
    output logic [7:0] irq_rises,
    output logic clk_raise_req
);
    logic irq_q;
    // The host reacts to fresh requests only, so a held level is counted once.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_q <= 1'b0;
            irq_rises <= 8'h00;
            clk_raise_req <= 1'b0;
        end
        else
        begin
            irq_q <= irq;
            if (irq && !irq_q)
                irq_rises <= irq_rises + 8'h01;
            clk_raise_req <= |pin_out;
        end
    end
endmodule
`default_nettype wire

// ### verif/ceflg_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "ceflg_defines.svh"
module ceflg_top_bench;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0] ext_in = 4'h0;
    logic [1:0] sub_in = 2'b00;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [1:0] pin_out;
    logic irq;
    logic [7:0] irq_rises;
    logic clk_raise;
    int fails = 0;
    int total_checks = 0;
    always #2 pclk = ~pclk;
    ceflg_top #(.NPINS(2)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .adc_overflow(ext_in[0]), .adc_cic_error(ext_in[1]),
        .adc_fifo_error(ext_in[2]), .mixer_drop(ext_in[3]),
        .sync_rate_converter_underclock(sub_in[0]), .serial_audio_port_underclock(sub_in[1]),
        .pin_out(pin_out), .irq(irq));
    ceflg_far_end #(.NPINS(2)) far (.pclk(pclk), .presetn(presetn), .pin_out(pin_out),
        .irq(irq), .irq_rises(irq_rises), .clk_raise_req(clk_raise));
    task automatic summarize;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
            fails++;
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] rd, output logic err);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 64);
        if (n >= 64)
        begin
            fails++;
            summarize();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0000_0000, r, e);
        chk(r, exp);
    endtask
    // Six cycles covers every input-to-pin and input-to-interrupt latency of the block.
    task automatic settle;
        repeat (6) @(posedge pclk);
    endtask
    task automatic test_reset;
        logic [31:0] r;
        logic e;
        rd(`CEFLG_OFS_BUDGET, `CEFLG_RST_BUDGET);
        rd(`CEFLG_OFS_PIN_FN, 32'h0000_0000);
        rd(`CEFLG_OFS_INT_EN, 32'h0000_0000);
        rd(`CEFLG_OFS_INT_STS, 32'h0000_0000);
        rd(`CEFLG_OFS_INT_CLR, 32'h0000_0000);
        apb(1'b0, 12'h034, 32'h0000_0000, r, e);
        chk({r[30:0], e}, 32'h0000_0001);
        chk({31'h0, irq}, 32'h0000_0000);
        $display("test_reset done");
    endtask
    task automatic test_ext_pins;
        logic [7:0] codes [4] = '{8'h17, 8'h18, 8'h19, 8'h27};
        for (int i = 0; i < 4; i++)
        begin
            wr(`CEFLG_OFS_PIN_FN, {24'h0, codes[i]});
            ext_in[i] <= 1'b1;
            settle();
            chk({30'h0, pin_out}, 32'h0000_0001);
            rd(`CEFLG_OFS_RAW, 32'h0000_0004 << i);
            ext_in[i] <= 1'b0;
            settle();
            chk({30'h0, pin_out}, 32'h0000_0000);
        end
        $display("test_ext_pins done");
    endtask
    task automatic test_irq;
        int c;
        wr(`CEFLG_OFS_INT_CLR, 32'h0000_00FF);
        wr(`CEFLG_OFS_INT_EN, 32'h0000_0004);
        c = irq_rises;
        ext_in[0] <= 1'b1;
        settle();
        chk({31'h0, irq}, 32'h0000_0001);
        wr(`CEFLG_OFS_INT_CLR, 32'h0000_0004);
        settle();
        chk({31'h0, irq}, 32'h0000_0000);
        ext_in[0] <= 1'b0;
        settle();
        chk({31'h0, irq}, 32'h0000_0001);
        chk({24'h0, irq_rises}, 32'(c + 2));
        wr(`CEFLG_OFS_INT_EN, 32'h0000_0000);
        wr(`CEFLG_OFS_INT_CLR, 32'h0000_0004);
        ext_in[0] <= 1'b1;
        settle();
        chk({31'h0, irq}, 32'h0000_0000);
        rd(`CEFLG_OFS_INT_STS, 32'h0000_0004);
        ext_in[0] <= 1'b0;
        settle();
        wr(`CEFLG_OFS_INT_CLR, 32'h0000_00FF);
        $display("test_irq done");
    endtask
    task automatic test_admission;
        logic [11:0] ofs [4] = '{`CEFLG_OFS_OUTA_PATH, `CEFLG_OFS_OUTB_PATH,
            `CEFLG_OFS_FX_PATH, `CEFLG_OFS_MIX_PATH};
        wr(`CEFLG_OFS_BUDGET, 32'h0008_0008);
        wr(`CEFLG_OFS_PIN_FN, 32'h0000_0B0A);
        wr(`CEFLG_OFS_IN_PATH, 32'h0000_0007);
        wr(`CEFLG_OFS_ASRC_PATH, 32'h0000_0003);
        settle();
        rd(`CEFLG_OFS_IN_PATH, 32'h0000_0003);
        rd(`CEFLG_OFS_ASRC_PATH, 32'h0000_0001);
        chk({30'h0, pin_out}, 32'h0000_0003);
        rd(`CEFLG_OFS_SUB_STS, 32'h0000_0005);
        rd(`CEFLG_OFS_RAW, 32'h0000_0043);
        wr(`CEFLG_OFS_PIN_FN, 32'h0000_2E2D);
        settle();
        chk({30'h0, pin_out}, 32'h0000_0001);
        chk({31'h0, clk_raise}, 32'h0000_0001);
        wr(`CEFLG_OFS_BUDGET, `CEFLG_RST_BUDGET);
        settle();
        rd(`CEFLG_OFS_IN_PATH, 32'h0000_0007);
        rd(`CEFLG_OFS_ASRC_PATH, 32'h0000_0003);
        chk({30'h0, pin_out}, 32'h0000_0000);
        chk({31'h0, clk_raise}, 32'h0000_0000);
        wr(`CEFLG_OFS_IN_PATH, 32'h0000_0000);
        wr(`CEFLG_OFS_ASRC_PATH, 32'h0000_0000);
        for (int i = 0; i < 4; i++)
        begin
            wr(ofs[i], 32'h0000_0001);
            settle();
            rd(ofs[i], 32'h0000_0001);
            wr(ofs[i], 32'h0000_0000);
        end
        // Every core-clock path requested at once asks for more than the ceiling.
        wr(`CEFLG_OFS_BUDGET, 32'hFFFF_FFFF);
        wr(`CEFLG_OFS_IN_PATH, 32'h0000_00FF);
        for (int i = 0; i < 4; i++)
        begin
            wr(ofs[i], 32'h0000_00FF);
        end
        settle();
        chk({31'h0, pin_out[1]}, 32'h0000_0001);
        wr(`CEFLG_OFS_IN_PATH, 32'h0000_0000);
        for (int i = 0; i < 4; i++)
        begin
            wr(ofs[i], 32'h0000_0000);
        end
        settle();
        chk({31'h0, pin_out[1]}, 32'h0000_0000);
        wr(`CEFLG_OFS_BUDGET, `CEFLG_RST_BUDGET);
        settle();
        $display("test_admission done");
    endtask
    task automatic test_sync;
        wr(`CEFLG_OFS_PIN_FN, 32'h0000_002D);
        for (int i = 0; i < 2; i++)
        begin
            sub_in[i] <= 1'b1;
            settle();
            rd(`CEFLG_OFS_SUB_STS, 32'h0000_0020 << i);
            chk({30'h0, pin_out}, 32'h0000_0001);
            sub_in[i] <= 1'b0;
            settle();
            chk({30'h0, pin_out}, 32'h0000_0000);
        end
        $display("test_sync done");
    endtask
    initial
    begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        test_reset();
        test_ext_pins();
        test_irq();
        test_admission();
        test_sync();
        summarize();
    end
endmodule
`default_nettype wire

// ### verif/ceflg_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "ceflg_defines.svh"
module ceflg_top_sva #(
    parameter int NPINS = 2
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic adc_overflow,
    input wire logic adc_cic_error,
    input wire logic adc_fifo_error,
    input wire logic mixer_drop,
    input wire logic sync_rate_converter_underclock,
    input wire logic serial_audio_port_underclock,
    input wire logic [NPINS-1:0] pin_out,
    input wire logic irq
);
    // A shadow of the pin selection lets pin behaviour be judged from the bus alone.
    logic [15:0] fn_q;
    logic ext_bit;
    logic ext_hit;
    assign ext_hit = fn_q[7:0] inside {8'h17, 8'h18, 8'h19, 8'h27};
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            fn_q <= 16'h0000;
        else if (psel && penable && pready && pwrite && paddr == `CEFLG_OFS_PIN_FN)
            fn_q <= pwdata[15:0];
    end
    always_comb
    begin
        case (fn_q[7:0])
            8'h17: ext_bit = adc_overflow;
            8'h18: ext_bit = adc_cic_error;
            8'h19: ext_bit = adc_fifo_error;
            default: ext_bit = mixer_drop;
        endcase
    end
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    a_ready_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready)
        else $error("pready not in second access cycle");
    a_err_gate: assert property (pslverr |-> pready)
        else $error("pslverr outside an answer");
    a_rdata_idle: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("read data not zero between answers");
    a_unmapped_err: assert property (pready && (paddr > `CEFLG_OFS_SUB_STS || paddr[1:0] != 2'b00)
        |-> pslverr) else $error("unmapped address without error");
    a_mapped_ok: assert property (pready && paddr <= `CEFLG_OFS_SUB_STS && paddr[1:0] == 2'b00
        |-> !pslverr) else $error("mapped address answered with error");
    a_clr_reads_zero: assert property (pready && !pwrite && paddr == `CEFLG_OFS_INT_CLR
        |-> prdata == 32'h0000_0000) else $error("clear register read not zero");
    a_quiet_reset: assert property ($rose(presetn) |-> pin_out == '0 && !irq && !pready)
        else $error("outputs active at reset release");
    a_pin_ext: assert property ($past(ext_hit) && $past(fn_q) == $past(fn_q, 2)
        |-> pin_out[0] == $past(ext_bit, 2)) else $error("pin 0 does not follow its source");
    a_pin_unused: assert property ($past(fn_q[15:8]) == 8'h00 |-> !pin_out[1])
        else $error("unselected pin 1 not low");
    c_error: cover property (pready && pslverr);
    c_fn_write: cover property (pready && pwrite && paddr == `CEFLG_OFS_PIN_FN);
    c_irq: cover property ($rose(irq));
    c_pin: cover property ($rose(pin_out[0]));
endmodule
bind ceflg_top ceflg_top_sva #(.NPINS(NPINS)) u_sva (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .adc_overflow(adc_overflow),
    .adc_cic_error(adc_cic_error), .adc_fifo_error(adc_fifo_error), .mixer_drop(mixer_drop),
    .sync_rate_converter_underclock(sync_rate_converter_underclock),
    .serial_audio_port_underclock(serial_audio_port_underclock), .pin_out(pin_out), .irq(irq));
`default_nettype wire
